/* File: inc/seha_pkg.sv */
package seha_pkg;

  localparam logic [11:0] OFS_CTRL = 12'h0A0;
  localparam logic [11:0] OFS_ADDR_DATA = 12'h0A4;
  localparam logic [11:0] OFS_INT_STAT = 12'h100;
  localparam logic [11:0] OFS_INT_MASK = 12'h104;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int CTRL_AL_OK_BIT = 4;
  localparam int CTRL_AL_DIS_BIT = 5;
  localparam int CTRL_RATE_LSB = 6;
  localparam int CTRL_STAT_LSB = 8;
  localparam int WORD_ADDR_LSB = 0;
  localparam int WORD_DATA_LSB = 16;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_AL_BIT = 1;
  localparam int INT_W = 2;

  localparam logic AL_DIS_RST = 1'b1;
  localparam logic [1:0] RATE_RST = 2'h1;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [INT_W-1:0] INT_RST = 2'h0;
  // Software may change only the block-protect and write-protect-enable bits.
  localparam logic [7:0] STAT_RW_MASK = 8'h8C;

  localparam int SCK_DIV_NORMAL = 64;
  localparam int SCK_DIV_TEST = 4;
  localparam int FRAME_W = 40;
  localparam logic [5:0] LEN_OP = 6'h08;
  localparam logic [5:0] LEN_STAT = 6'h10;
  localparam logic [5:0] LEN_WORD = 6'h28;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_WRSR = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_READ = 3'b011,
    CMD_WRDI = 3'b100,
    CMD_RDSR = 3'b101,
    CMD_WREN = 3'b110,
    CMD_RSVD = 3'b111
  } seha_cmd_t;

  typedef enum logic [1:0] {
    RATE_RSVD0 = 2'b00,
    RATE_DIV64 = 2'b01,
    RATE_RSVD2 = 2'b10,
    RATE_TEST = 2'b11
  } seha_rate_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } seha_state_t;

  typedef struct packed {
    logic [5:0] len;
    logic [FRAME_W-1:0] bits;
  } seha_frame_t;

  // Reserved rate codes fall back to the normal divide so the link never stalls.
  function automatic logic [5:0] half_period(input logic [1:0] rate);
    if (rate == RATE_TEST)
      half_period = 6'(SCK_DIV_TEST / 2);
    else
      half_period = 6'(SCK_DIV_NORMAL / 2);
  endfunction

endpackage

/* File: logic/seha_clkdiv.sv */
`timescale 1ns/1ps
module seha_clkdiv
  import seha_pkg::*;
#(
  parameter int CW = 6
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic [CW-1:0] half,
  output logic tick
);

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else if (clear)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else if (cnt_reg == half - CW'(1))
    begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule

/* File: logic/seha_spi.sv */
`timescale 1ns/1ps
module seha_spi
  import seha_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic start,
  input wire seha_frame_t frame,
  input wire logic miso,
  output logic busy,
  output logic done,
  output logic [FRAME_W-1:0] rx,
  output logic sck,
  output logic cs_n,
  output logic mosi
);

  logic [FRAME_W-1:0] tx_reg;
  logic [5:0] left_reg;

  // Mode 0: data changes on the falling edge, is sampled on the rising edge.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rx <= '0;
      sck <= 1'b0;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      tx_reg <= '0;
      left_reg <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        cs_n <= 1'b0;
        sck <= 1'b0;
        mosi <= frame.bits[FRAME_W-1];
        tx_reg <= {frame.bits[FRAME_W-2:0], 1'b0};
        left_reg <= frame.len;
        rx <= '0;
      end
      else if (busy && tick)
      begin
        if (!sck)
        begin
          sck <= 1'b1;
          rx <= {rx[FRAME_W-2:0], miso};
        end
        else if (left_reg == 6'h01)
        begin
          sck <= 1'b0;
          cs_n <= 1'b1;
          busy <= 1'b0;
          done <= 1'b1;
          mosi <= 1'b0;
        end
        else
        begin
          sck <= 1'b0;
          mosi <= tx_reg[FRAME_W-1];
          tx_reg <= {tx_reg[FRAME_W-2:0], 1'b0};
          left_reg <= left_reg - 6'h01;
        end
      end
    end
  end

endmodule

/* File: logic/seha_top.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module seha_top
  import seha_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic autoload_done,
  input wire logic autoload_pass,
  output logic eeprom_sck,
  output logic eeprom_cs_n,
  output logic eeprom_mosi,
  input wire logic eeprom_miso,
  output logic irq
);

  seha_state_t state_reg;
  logic start_reg;
  seha_cmd_t cmd_reg;
  logic al_ok_reg;
  logic al_dis_reg;
  logic [1:0] rate_reg;
  logic [7:0] stat_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [INT_W-1:0] int_stat_reg;
  logic [INT_W-1:0] int_mask_reg;
  logic go_reg;
  logic rate_wr_reg;
  seha_frame_t frame_reg;
  logic tick;
  logic spi_busy;
  logic spi_done;
  logic [FRAME_W-1:0] spi_rx;
  logic wr_en;
  logic [7:0] stat_wr;
  logic idle;
  logic launch;
  logic [INT_W-1:0] int_set;

  // The answer takes one wait state, so the access edge is the one with pready high.
  assign wr_en = psel && penable && pready && pwrite;
  assign idle = (state_reg == ST_IDLE);
  assign launch = wr_en && idle && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];
  assign int_set = {autoload_done, (state_reg != ST_IDLE) && (spi_done || state_reg == ST_DONE)};
  assign stat_wr = (stat_reg & ~STAT_RW_MASK) | (pwdata[CTRL_STAT_LSB +: 8] & STAT_RW_MASK);

  function automatic seha_frame_t build_frame(input seha_cmd_t cmd, input logic [15:0] adr,
                                              input logic [15:0] dat, input logic [7:0] st);
    logic [7:0] op;
    op = {5'h00, cmd};
    build_frame.len = LEN_OP;
    build_frame.bits = {op, 32'h00000000};
    case (cmd)
      CMD_WRSR:
      begin
        build_frame.len = LEN_STAT;
        build_frame.bits = {op, st, 24'h000000};
      end
      CMD_WRITE:
      begin
        build_frame.len = LEN_WORD;
        build_frame.bits = {op, adr, dat};
      end
      CMD_READ:
      begin
        build_frame.len = LEN_WORD;
        build_frame.bits = {op, adr, 16'h0000};
      end
      CMD_RDSR:
        build_frame.len = LEN_STAT;
      default:
        build_frame.len = LEN_OP;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr == OFS_CTRL)
        prdata <= {16'h0000, stat_reg, rate_reg, al_dis_reg, al_ok_reg, cmd_reg, start_reg};
      else if (paddr == OFS_ADDR_DATA)
        prdata <= {data_reg, addr_reg};
      else if (paddr == OFS_INT_STAT)
        prdata <= {30'h00000000, int_stat_reg};
      else if (paddr == OFS_INT_MASK)
        prdata <= {30'h00000000, int_mask_reg};
      else
        pslverr <= 1'b1;
    end
  end

  // Command sequencing; control and word writes are refused while a cycle runs.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_IDLE;
      start_reg <= 1'b0;
      cmd_reg <= CMD_NONE;
      go_reg <= 1'b0;
      frame_reg <= '0;
    end
    else
    begin
      go_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (wr_en && paddr == OFS_CTRL)
            cmd_reg <= seha_cmd_t'(pwdata[CTRL_CMD_LSB +: 3]);
          if (launch)
          begin
            start_reg <= 1'b1;
            frame_reg <= build_frame(seha_cmd_t'(pwdata[CTRL_CMD_LSB +: 3]), addr_reg,
                                     data_reg, stat_wr);
            if (pwdata[CTRL_CMD_LSB +: 3] == CMD_NONE || pwdata[CTRL_CMD_LSB +: 3] == CMD_RSVD)
              state_reg <= ST_DONE;
            else
            begin
              state_reg <= ST_RUN;
              go_reg <= 1'b1;
            end
          end
        end
        ST_RUN:
        begin
          if (spi_done)
          begin
            state_reg <= ST_IDLE;
            start_reg <= 1'b0;
          end
        end
        ST_DONE:
        begin
          state_reg <= ST_IDLE;
          start_reg <= 1'b0;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      al_dis_reg <= AL_DIS_RST;
      rate_reg <= RATE_RST;
      rate_wr_reg <= 1'b0;
    end
    else
    begin
      rate_wr_reg <= 1'b0;
      if (wr_en && idle && paddr == OFS_CTRL)
      begin
        al_dis_reg <= pwdata[CTRL_AL_DIS_BIT];
        rate_reg <= pwdata[CTRL_RATE_LSB +: 2];
        rate_wr_reg <= (pwdata[CTRL_RATE_LSB +: 2] != rate_reg);
      end
    end
  end

  // A disabled or failed load clears the success flag.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      al_ok_reg <= 1'b0;
    else if (al_dis_reg)
      al_ok_reg <= 1'b0;
    else if (autoload_done)
      al_ok_reg <= autoload_pass;
  end

  // Status mirror: a completed status read wins over anything else.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      stat_reg <= STAT_RST;
    else if (state_reg == ST_RUN && spi_done && cmd_reg == CMD_RDSR)
      stat_reg <= spi_rx[7:0];
    else if (wr_en && idle && paddr == OFS_CTRL)
      stat_reg <= stat_wr;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_reg <= ADDR_RST;
      data_reg <= DATA_RST;
    end
    else if (state_reg == ST_RUN && spi_done && cmd_reg == CMD_READ)
      data_reg <= spi_rx[15:0];
    else if (wr_en && idle && paddr == OFS_ADDR_DATA)
    begin
      addr_reg <= pwdata[WORD_ADDR_LSB +: 16];
      data_reg <= pwdata[WORD_DATA_LSB +: 16];
    end
  end

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      int_stat_reg <= INT_RST;
      int_mask_reg <= INT_RST;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == OFS_INT_STAT)
        int_stat_reg <= (int_stat_reg & ~pwdata[INT_W-1:0]) | int_set;
      else
        int_stat_reg <= int_stat_reg | int_set;
      if (wr_en && paddr == OFS_INT_MASK)
        int_mask_reg <= pwdata[INT_W-1:0];
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  seha_clkdiv #(.CW(6)) u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(rate_wr_reg),
    .half(half_period(rate_reg)),
    .tick(tick)
  );

  seha_spi u_spi (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(tick),
    .start(go_reg),
    .frame(frame_reg),
    .miso(eeprom_miso),
    .busy(spi_busy),
    .done(spi_done),
    .rx(spi_rx),
    .sck(eeprom_sck),
    .cs_n(eeprom_cs_n),
    .mosi(eeprom_mosi)
  );

  logic [5:0] gap_reg;
  logic gap_valid_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap_reg <= '0;
      gap_valid_reg <= 1'b0;
    end
    else if (rate_wr_reg)
    begin
      gap_reg <= '0;
      gap_valid_reg <= 1'b0;
    end
    else if (tick)
    begin
      gap_reg <= '0;
      gap_valid_reg <= 1'b1;
    end
    else
      gap_reg <= gap_reg + 6'h01;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_launch_cmd;
    launch && pwdata[CTRL_CMD_LSB +: 3] != CMD_NONE && pwdata[CTRL_CMD_LSB +: 3] != CMD_RSVD;
  endsequence

  sequence s_go_busy;
    go_reg && start_reg ##1 spi_busy && !eeprom_cs_n;
  endsequence

  a_start_launch:
    assert property (s_launch_cmd |=> s_go_busy)
    else $error("start write did not launch a serial cycle");

  a_opcode_low:
    assert property (go_reg && cmd_reg inside {CMD_WRSR, CMD_WRITE, CMD_READ}
                     |-> frame_reg.bits[39:32] == {5'h00, cmd_reg})
    else $error("opcode differs from command code");
  a_opcode_high:
    assert property (go_reg && cmd_reg inside {CMD_WRDI, CMD_RDSR, CMD_WREN}
                     |-> frame_reg.bits[39:32] == {5'h00, cmd_reg} && frame_reg.len != LEN_WORD)
    else $error("control opcode or length wrong");

  a_autoload_flag:
    assert property ($rose(al_ok_reg) |-> $past(autoload_done && autoload_pass && !al_dis_reg))
    else $error("autoload flag set without success");

  a_tick_gap:
    assert property (tick && gap_valid_reg && !rate_wr_reg
                     |-> gap_reg == half_period(rate_reg) - 6'h01)
    else $error("serial clock divide wrong");

  a_status_mirror:
    assert property (state_reg == ST_RUN && spi_done && cmd_reg == CMD_RDSR
                     |=> stat_reg == $past(spi_rx[7:0]))
    else $error("status mirror not updated");
  a_wrsr_frame:
    assert property (go_reg && cmd_reg == CMD_WRSR
                     |-> frame_reg.bits[31:24] == stat_reg && frame_reg.len == LEN_STAT)
    else $error("status write frame wrong");
  a_word_frame:
    assert property (go_reg && cmd_reg == CMD_WRITE
                     |-> frame_reg.bits[31:0] == {addr_reg, data_reg})
    else $error("word write frame wrong");

  a_start_clear:
    assert property (state_reg == ST_RUN && spi_done |=> !start_reg && idle)
    else $error("start bit not cleared at end");
  a_read_data:
    assert property (state_reg == ST_RUN && spi_done && cmd_reg == CMD_READ
                     |=> data_reg == $past(spi_rx[15:0]))
    else $error("read data not returned");

  a_irq_level:
    assert property (|(int_stat_reg & int_mask_reg) |=> irq)
    else $error("interrupt not raised");

endmodule

/* File: testbench/seha_eeprom_model.sv */
`timescale 1ns/1ps
module seha_eeprom_model
(
  input wire logic sys_clk,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  logic [15:0] mem [logic [15:0]];
  logic [39:0] sh = '0;
  logic [15:0] ad = '0, rw = '0;
  logic [7:0] op = '0, st = '0;
  int n = 0;
  initial
  begin
    miso = 1'h0;
  end
  // An undriven line must not keep showing the last bit, so it toggles between frames.
  always @(posedge sys_clk)
  begin
    if (cs_n)
      miso <= ~miso;
  end
  always @(negedge cs_n)
  begin
    n = 0;
  end
  always @(posedge sck)
  begin
    sh = {sh[38:0], mosi};
    n++;
    if (n == 8)
      op = sh[7:0];
    if (n == 24)
    begin
      ad = sh[15:0];
      rw = mem.exists(ad) ? mem[ad] : ~ad;
    end
  end
  always @(negedge sck)
  begin
    if (op == 8'h03 && n >= 24 && n < 40)
      miso = rw[39-n];
    else if (op == 8'h05 && n >= 8 && n < 16)
      miso = st[15-n];
    else
      miso = ~miso;
  end
  // Writes land only while the latch is set, and both kinds of write clear it.
  always @(posedge cs_n)
  begin
    case (op)
      8'h06: st[1] = 1'h1;
      8'h04: st[1] = 1'h0;
      8'h05: st[0] = 1'h0;
      8'h02:
        if (st[1] && n == 40)
        begin
          mem[ad] = sh[15:0];
          st[1:0] = 2'h1;
        end
      8'h01:
        if (st[1] && n == 16)
          st = {sh[7], 3'h0, sh[3:2], 2'h0};
      default: ;
    endcase
  end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb
  import seha_pkg::*;
;
  logic sys_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, qe, irq, eeprom_sck, eeprom_cs_n, eeprom_mosi, eeprom_miso;
  logic autoload_done = 1'h0, autoload_pass = 1'h0;
  int fails = 0, checks_done = 0, frames = 0, mon_n = 0, cyc = 0, last = 0, per = 0;
  logic [39:0] mon_sh = '0;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] da, dd;
  logic [7:0] m_st = 8'h00, bp = 8'h00;
  logic wel = 1'h0, wip = 1'h0;
  logic [2:0] seq [15] = '{3'h6, 3'h5, 3'h2, 3'h5, 3'h5, 3'h3, 3'h6, 3'h1, 3'h5, 3'h6,
    3'h5, 3'h4, 3'h5, 3'h0, 3'h7};

  seha_top uut (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .autoload_done(autoload_done), .autoload_pass(autoload_pass),
    .eeprom_sck(eeprom_sck), .eeprom_cs_n(eeprom_cs_n), .eeprom_mosi(eeprom_mosi),
    .eeprom_miso(eeprom_miso), .irq(irq));
  seha_eeprom_model mem_chip (.sys_clk(sys_clk), .sck(eeprom_sck), .cs_n(eeprom_cs_n),
    .mosi(eeprom_mosi), .miso(eeprom_miso));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc++;
  always @(negedge eeprom_cs_n)
  begin
    frames++;
    mon_n = 0;
  end
  always @(posedge eeprom_sck)
  begin
    mon_sh = {mon_sh[38:0], eeprom_mosi};
    mon_n++;
    per = cyc - last;
    last = cyc;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    chk("pready", 1'h1, pready);
    if (pready !== 1'h1)
      conclude();
    q = prdata;
    qe = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic pulse_load(input logic p);
    autoload_pass <= p;
    autoload_done <= 1'h1;
    @(posedge sys_clk);
    autoload_done <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic run_cmd(input logic [2:0] c, input logic [1:0] rt);
    int f0, k, ln;
    logic [7:0] sb;
    logic [39:0] ef, em;
    f0 = frames;
    sb = (c == 3'h1) ? 8'h8C : m_st;
    m_st = (m_st & 8'h03) | (sb & 8'h8C);
    if (c == 3'h3)
      apb(1'h1, OFS_ADDR_DATA, {~dd, da});
    apb(1'h1, OFS_CTRL, {16'h0000, sb, rt, 2'h2, c, 1'h1});
    apb(1'h1, OFS_ADDR_DATA, ~{dd, da});
    if (c == 3'h0 || c == 3'h7)
      {dd, da} = ~{dd, da};
    k = 0;
    do
    begin
      apb(1'h0, OFS_CTRL, 32'h0);
      k++;
    end
    while (q[0] !== 1'h0 && k < 3000);
    chk("start", 1'h0, q[0]);
    if (q[0] !== 1'h0)
      conclude();
    ln = (c == 3'h0 || c == 3'h7) ? 0 : 8;
    ef = {32'h0, 5'h00, c};
    em = 40'hFF;
    case (c)
      3'h6: wel = 1'h1;
      3'h4: wel = 1'h0;
      3'h2:
      begin
        ln = 40;
        ef = {5'h00, c, da, dd};
        em = '1;
        if (wel)
        begin
          mem[da] = dd;
          wip = 1'h1;
          wel = 1'h0;
        end
      end
      3'h3:
      begin
        ln = 40;
        ef = {5'h00, c, da, 16'h0000};
        em = 40'hFFFFFF0000;
        dd = mem.exists(da) ? mem[da] : ~da;
      end
      3'h1:
      begin
        ln = 16;
        ef = {24'h0, 5'h00, c, 8'h8C};
        em = 40'hFF8C;
        if (wel)
          bp = 8'h8C;
        wel = 1'h0;
      end
      3'h5:
      begin
        ln = 16;
        ef = {24'h0, 5'h00, c, 8'h00};
        em = 40'hFF00;
        m_st = bp | {6'h00, wel, wip};
        wip = 1'h0;
      end
      default: ;
    endcase
    chk("frames", ln > 0, frames - f0);
    chk("control", {16'h0000, m_st, rt, 2'h2, c, 1'h0}, q);
    rd(OFS_ADDR_DATA, {dd, da});
    if (ln > 0)
    begin
      chk("bits", ln, mon_n);
      chk("frame", ef, mon_sh & em);
      chk("period", (rt == 2'h3) ? 4 : 64, per);
    end
    rd(OFS_INT_STAT, 32'h1);
    chk("irq", 1'h1, irq);
    apb(1'h1, OFS_INT_STAT, 32'h1);
    rd(OFS_INT_STAT, 32'h0);
    chk("irq", 1'h0, irq);
  endtask

  initial
  begin
    void'($urandom(35));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    rd(OFS_CTRL, 32'h00000060);
    rd(OFS_ADDR_DATA, 32'h0);
    rd(OFS_INT_STAT, 32'h0);
    rd(OFS_INT_MASK, 32'h0);
    apb(1'h0, 12'h0A8, 32'h0);
    chk("error", 1'h1, qe);
    apb(1'h1, OFS_CTRL, 32'h0000FFFE);
    rd(OFS_CTRL, 32'h00008CEE);
    apb(1'h1, OFS_CTRL, 32'h00000060);
    da = 16'($urandom);
    dd = 16'($urandom);
    apb(1'h1, OFS_ADDR_DATA, {dd, da});
    rd(OFS_ADDR_DATA, {dd, da});
    pulse_load(1'h1);
    rd(OFS_CTRL, 32'h00000060);
    apb(1'h1, OFS_INT_STAT, 32'h3);
    apb(1'h1, OFS_INT_MASK, 32'h1);
    apb(1'h1, OFS_CTRL, 32'h00000040);
    pulse_load(1'h1);
    rd(OFS_CTRL, 32'h00000050);
    rd(OFS_INT_STAT, 32'h2);
    chk("irq", 1'h0, irq);
    apb(1'h1, OFS_INT_MASK, 32'h3);
    rd(OFS_INT_MASK, 32'h3);
    chk("irq", 1'h1, irq);
    apb(1'h1, OFS_INT_STAT, 32'h2);
    pulse_load(1'h0);
    rd(OFS_CTRL, 32'h00000040);
    apb(1'h1, OFS_INT_STAT, 32'h3);
    apb(1'h1, OFS_CTRL, 32'h00000060);
    foreach (seq[i]) run_cmd(seq[i], 2'h1);
    run_cmd(3'h6, 2'h3);
    conclude();
  end
endmodule
